// ===== lpmc.sv
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_params.svh"

// Summary of operation
// - Bus clock is oscillator divided by two
// - Low reset pin holds defined start state
// - Reset clears port regs except data
// - Connect bit routes peripheral to pin
// - Stop turns oscillator off, halts everything
// - Stop entry clears timer flags and enables
// - Stop entry clears the timer prescaler
// - Stop entry clears the interrupt mask
// - Stop keeps all other state unchanged
// - Only external interrupt or reset wakes stop
// - Stop disabled by option acts as nop
// - Wait halts CPU, peripherals stay clocked
// - Enabled peripheral interrupt ends wait
// - Wait entry clears mask, keeps rest
// - Core timer may run to wake wait
// - Reset release resumes operation from reset
module lpmc #(
  parameter bit STOP_DISABLE = 1'b0,
  parameter int STAB_CYCLES = `LPMC_STAB_US * `LPMC_CLK_MHZ,
  parameter int PRESC_W = 7
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic reset_n_pin_in,
  // Register port
  input wire lpmc_pkg::lpmc_req_s req_in,
  output logic [7:0] rdata_out,
  // CPU instruction events and state
  input wire logic stop_exec_in,
  input wire logic wait_exec_in,
  output logic cpu_halt_out,
  output logic irq_mask_out,
  output logic core_irq_out,
  // Clocking
  output logic osc_on_out,
  output logic bus_clk_en_out,
  output logic periph_clk_en_out,
  output logic [1:0] mode_out,
  // Wake sources
  input wire logic ext_irq_n_pin_in,
  input wire logic timer16_irq_in,
  input wire logic serial_irq_in,
  // Shared port
  input wire logic [5:0] port_pin_in,
  input wire lpmc_pkg::lpmc_periph_s timer16_pins_in,
  input wire lpmc_pkg::lpmc_periph_s serial_pins_in,
  output logic [5:0] port_dout_out,
  output logic [5:0] port_oe_out,
  output logic [5:0] port_pullup_out,
  output logic [5:0] port_din_out
);

  ////////////////////////////////////////////////////////////////////////////
  logic [2:0] rst_sync_r;
  logic rst_lvl_r;
  logic [2:0] xirq_sync_r;
  logic xirq_lvl_r;
  logic [5:0] pin_s1_r;
  logic [5:0] pin_s2_r;
  logic [5:0] pin_s3_r;
  logic [5:0] pin_lvl_r;
  logic rst;

  // Pin inputs: three stages, level accepted when stages two and three agree
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      rst_sync_r <= 3'h0;
      rst_lvl_r <= 1'b0;
    end
    else
    begin
      rst_sync_r <= {rst_sync_r[1:0], reset_n_pin_in};
      if (rst_sync_r[1] == rst_sync_r[2])
        rst_lvl_r <= rst_sync_r[2];
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      xirq_sync_r <= 3'h7;
      xirq_lvl_r <= 1'b1;
    end
    else
    begin
      xirq_sync_r <= {xirq_sync_r[1:0], ext_irq_n_pin_in};
      if (xirq_sync_r[1] == xirq_sync_r[2])
        xirq_lvl_r <= xirq_sync_r[2];
    end
  end

  always_ff @(posedge clock_in)
  begin
    pin_s1_r <= port_pin_in;
    pin_s2_r <= pin_s1_r;
    pin_s3_r <= pin_s2_r;
    if (sys_rst_in)
      pin_lvl_r <= 6'h00;
    else
      pin_lvl_r <= (pin_s2_r & pin_s3_r) | (pin_lvl_r & (pin_s2_r ^ pin_s3_r));
  end

  // Held for as long as the pin is low; release resumes from reset
  assign rst = sys_rst_in | ~rst_lvl_r;

  ////////////////////////////////////////////////////////////////////////////
  lpmc_pkg::lpmc_mode_e mode_r;
  logic [$clog2(STAB_CYCLES+1)-1:0] stab_cnt_r;
  logic div_r;
  logic bus_en;
  logic osc_on;
  logic stop_go;
  logic wait_go;
  logic wait_wake;
  logic core_irq;
  logic [7:0] ctcs_r;

  assign osc_on = (mode_r != lpmc_pkg::LPMC_STOP);
  assign stop_go = stop_exec_in && !STOP_DISABLE &&
                   (mode_r == lpmc_pkg::LPMC_RUN);
  assign wait_go = wait_exec_in && !stop_exec_in &&
                   (mode_r == lpmc_pkg::LPMC_RUN);
  assign core_irq = (ctcs_r[`LPMC_CT_OVF_FLAG] & ctcs_r[`LPMC_CT_OVF_EN]) |
                    (ctcs_r[`LPMC_CT_TICK_FLAG] & ctcs_r[`LPMC_CT_TICK_EN]);
  assign wait_wake = core_irq | timer16_irq_in | serial_irq_in |
                     ~xirq_lvl_r;

  // Oscillator divided by two; stalls while the oscillator is off
  always_ff @(posedge clock_in)
  begin
    if (rst)
      div_r <= 1'b0;
    else if (osc_on)
      div_r <= ~div_r;
  end

  assign bus_en = div_r && (mode_r == lpmc_pkg::LPMC_RUN ||
                            mode_r == lpmc_pkg::LPMC_WAIT);

  always_ff @(posedge clock_in)
  begin
    if (rst)
    begin
      mode_r <= lpmc_pkg::LPMC_RUN;
      stab_cnt_r <= '0;
    end
    else
    begin
      case (mode_r)
        lpmc_pkg::LPMC_RUN:
        begin
          if (stop_go)
            mode_r <= lpmc_pkg::LPMC_STOP;
          else if (wait_go)
            mode_r <= lpmc_pkg::LPMC_WAIT;
        end
        lpmc_pkg::LPMC_WAIT:
        begin
          if (wait_wake)
            mode_r <= lpmc_pkg::LPMC_RUN;
        end
        lpmc_pkg::LPMC_STOP:
        begin
          // Nothing but the external interrupt or a reset leaves here
          if (!xirq_lvl_r)
          begin
            mode_r <= lpmc_pkg::LPMC_STAB;
            stab_cnt_r <= '0;
          end
        end
        lpmc_pkg::LPMC_STAB:
        begin
          if (stab_cnt_r == ($bits(stab_cnt_r))'(STAB_CYCLES - 1))
            mode_r <= lpmc_pkg::LPMC_RUN;
          else
            stab_cnt_r <= stab_cnt_r + 1'b1;
        end
        default: mode_r <= lpmc_pkg::LPMC_RUN;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [PRESC_W-1:0] presc_r;
  logic [7:0] ctr_r;
  logic ovf_set;
  logic tick_set;
  logic [7:0] tick_mask;
  logic presc_wrap;
  logic [7:0] ccr_r;
  logic wr_ctcs;

  // Core timer keeps counting in wait so it can serve as a wake source
  assign presc_wrap = bus_en && (presc_r == {PRESC_W{1'b1}});
  assign ovf_set = presc_wrap && (ctr_r == 8'hFF);

  always_comb
  begin
    case (ctcs_r[`LPMC_CT_RATE_HI:`LPMC_CT_RATE_LO])
      2'h0: tick_mask = 8'h0F;
      2'h1: tick_mask = 8'h1F;
      2'h2: tick_mask = 8'h3F;
      default: tick_mask = 8'h7F;
    endcase
  end

  assign tick_set = presc_wrap && ((ctr_r & tick_mask) == tick_mask);
  assign wr_ctcs = req_in.wr && req_in.addr == `LPMC_OFS_CTCS;

  always_ff @(posedge clock_in)
  begin
    if (rst || stop_go)
      presc_r <= '0;
    else if (bus_en)
      presc_r <= presc_r + 1'b1;
  end

  // The counter itself survives stop
  always_ff @(posedge clock_in)
  begin
    if (rst)
      ctr_r <= 8'h00;
    else if (presc_wrap)
      ctr_r <= ctr_r + 8'h01;
  end

  // Flags clear by writing one; a set in the same cycle wins
  always_ff @(posedge clock_in)
  begin
    if (rst)
      ctcs_r <= `LPMC_RST_CTCS;
    else if (stop_go)
    begin
      ctcs_r[`LPMC_CT_OVF_FLAG] <= 1'b0;
      ctcs_r[`LPMC_CT_TICK_FLAG] <= 1'b0;
      ctcs_r[`LPMC_CT_OVF_EN] <= 1'b0;
      ctcs_r[`LPMC_CT_TICK_EN] <= 1'b0;
    end
    else
    begin
      if (ovf_set)
        ctcs_r[`LPMC_CT_OVF_FLAG] <= 1'b1;
      else if (wr_ctcs && req_in.wdata[`LPMC_CT_OVF_FLAG])
        ctcs_r[`LPMC_CT_OVF_FLAG] <= 1'b0;
      if (tick_set)
        ctcs_r[`LPMC_CT_TICK_FLAG] <= 1'b1;
      else if (wr_ctcs && req_in.wdata[`LPMC_CT_TICK_FLAG])
        ctcs_r[`LPMC_CT_TICK_FLAG] <= 1'b0;
      if (wr_ctcs)
        ctcs_r[5:0] <= req_in.wdata[5:0];
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst)
      ccr_r <= `LPMC_RST_CCR;
    else if (stop_go || wait_go)
      ccr_r[`LPMC_CCR_IMASK] <= 1'b0;
    else if (req_in.wr && req_in.addr == `LPMC_OFS_CCR)
      ccr_r <= req_in.wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [5:0] pdata_r;
  logic [5:0] pdir_r;
  logic [5:0] pconn_r;
  logic [5:0] psel_r;
  logic [5:0] drv_out;
  logic [5:0] drv_oe;

  // Data register is left alone by reset, as on the pins of old
  always_ff @(posedge clock_in)
  begin
    if (req_in.wr && req_in.addr == `LPMC_OFS_PDATA)
      pdata_r <= req_in.wdata[5:0];
  end

  always_ff @(posedge clock_in)
  begin
    if (rst)
    begin
      pdir_r <= `LPMC_RST_PORT;
      pconn_r <= `LPMC_RST_PORT;
      psel_r <= `LPMC_RST_PORT;
    end
    else if (req_in.wr)
    begin
      if (req_in.addr == `LPMC_OFS_PDIR)
        pdir_r <= req_in.wdata[5:0];
      if (req_in.addr == `LPMC_OFS_PCONN)
        pconn_r <= req_in.wdata[5:0];
      if (req_in.addr == `LPMC_OFS_PSEL)
        psel_r <= req_in.wdata[5:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_pin
      always_comb
      begin
        if (pconn_r[gi])
        begin
          drv_out[gi] = psel_r[gi] ? serial_pins_in.dout[gi] :
                                     timer16_pins_in.dout[gi];
          drv_oe[gi] = psel_r[gi] ? serial_pins_in.oe[gi] :
                                    timer16_pins_in.oe[gi];
        end
        else
        begin
          drv_out[gi] = pdir_r[gi] & pdata_r[gi];
          drv_oe[gi] = pdir_r[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Every output registered; pins keep their state through stop and wait
  always_ff @(posedge clock_in)
  begin
    if (rst)
    begin
      port_dout_out <= 6'h00;
      port_oe_out <= 6'h00;
      port_pullup_out <= 6'h3F;
      port_din_out <= 6'h00;
    end
    else
    begin
      port_dout_out <= drv_out & drv_oe;
      port_oe_out <= drv_oe;
      port_pullup_out <= ~drv_oe & ~pconn_r;
      port_din_out <= pin_lvl_r;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst)
    begin
      cpu_halt_out <= 1'b0;
      osc_on_out <= 1'b1;
      bus_clk_en_out <= 1'b0;
      periph_clk_en_out <= 1'b0;
      mode_out <= 2'h0;
      irq_mask_out <= 1'b1;
      core_irq_out <= 1'b0;
    end
    else
    begin
      cpu_halt_out <= (mode_r != lpmc_pkg::LPMC_RUN);
      osc_on_out <= osc_on;
      bus_clk_en_out <= bus_en && mode_r == lpmc_pkg::LPMC_RUN;
      periph_clk_en_out <= bus_en;
      mode_out <= mode_r;
      irq_mask_out <= ccr_r[`LPMC_CCR_IMASK];
      core_irq_out <= core_irq;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst || !req_in.rd)
      rdata_out <= 8'h00;
    else
    begin
      case (req_in.addr)
        `LPMC_OFS_PDATA: rdata_out <= {2'h0, pin_lvl_r};
        `LPMC_OFS_PDIR: rdata_out <= {2'h0, pdir_r};
        `LPMC_OFS_PCONN: rdata_out <= {2'h0, pconn_r};
        `LPMC_OFS_PSEL: rdata_out <= {2'h0, psel_r};
        `LPMC_OFS_CTCS: rdata_out <= ctcs_r;
        `LPMC_OFS_CCR: rdata_out <= ccr_r;
        `LPMC_OFS_STAT: rdata_out <= {6'h00, mode_r};
        `LPMC_OFS_PRESC: rdata_out <= ctr_r;
        default: rdata_out <= 8'h00;
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== lpmc_params.svh
`ifndef LPMC_PARAMS_SVH
`define LPMC_PARAMS_SVH

// Register offsets on the plain register port
`define LPMC_OFS_PDATA 4'h0
`define LPMC_OFS_PDIR 4'h1
`define LPMC_OFS_PCONN 4'h2
`define LPMC_OFS_PSEL 4'h3
`define LPMC_OFS_CTCS 4'h4
`define LPMC_OFS_CCR 4'h5
`define LPMC_OFS_STAT 4'h6
`define LPMC_OFS_PRESC 4'h7

// Core timer control/status fields
`define LPMC_CT_OVF_FLAG 7
`define LPMC_CT_TICK_FLAG 6
`define LPMC_CT_OVF_EN 5
`define LPMC_CT_TICK_EN 4
`define LPMC_CT_RATE_HI 1
`define LPMC_CT_RATE_LO 0

// Condition flags field
`define LPMC_CCR_IMASK 3

// Reset values
`define LPMC_RST_PORT 6'h00
`define LPMC_RST_CTCS 8'h00
`define LPMC_RST_CCR 8'h08

// Oscillator restart wait after stop, in microseconds
`define LPMC_STAB_US 25
`define LPMC_CLK_MHZ 200

`endif

// ===== lpmc_pkg.sv
package lpmc_pkg;

  typedef enum logic [1:0] {
    LPMC_RUN,
    LPMC_WAIT,
    LPMC_STOP,
    LPMC_STAB
  } lpmc_mode_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } lpmc_req_s;

  typedef struct packed {
    logic [5:0] dout;
    logic [5:0] oe;
  } lpmc_periph_s;

endpackage

// ===== lpmc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module lpmc_checker #(
  parameter bit STOP_DISABLE = 1'b0,
  parameter int STAB_CYCLES = 8
) (
  // Watched ports
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic reset_n_pin_in,
  input wire logic stop_exec_in,
  input wire logic wait_exec_in,
  input wire logic irq_mask_out,
  input wire logic core_irq_out,
  input wire logic bus_clk_en_out,
  input wire logic [1:0] mode_out,
  input wire logic ext_irq_n_pin_in,
  input wire logic timer16_irq_in,
  input wire logic serial_irq_in,
  input wire logic [5:0] port_oe_out,
  input wire logic [5:0] port_pullup_out
);
  int stab_cnt;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  always_ff @(posedge clock_in)
  begin
    stab_cnt <= (mode_out == 2'd3) ? stab_cnt + 1 : 0;
  end
  ////////////////////////////////////////////////////////////////////////
  property p_div2; bus_clk_en_out |=> !bus_clk_en_out; endproperty
  a_div2: assert property (p_div2) else $error("bus enable too dense");
  property p_stop; stop_exec_in && mode_out == 2'd0 && !$past(wait_exec_in)
    |-> ##2 mode_out == (STOP_DISABLE ? 2'd0 : 2'd2); endproperty
  a_stop: assert property (p_stop) else $error("stop entry wrong");
  property p_sent; $rose(mode_out == 2'd2) |-> !irq_mask_out && !core_irq_out;
  endproperty
  a_sent: assert property (p_sent) else $error("stop entry state");
  property p_hold; (mode_out == 2'd2 && ext_irq_n_pin_in && reset_n_pin_in)
    [*6] |=> mode_out == 2'd2; endproperty
  a_hold: assert property (p_hold) else $error("stop left early");
  property p_exit; mode_out == 2'd2 ##1 mode_out != 2'd2
    |-> mode_out == 2'd3 || !reset_n_pin_in; endproperty
  a_exit: assert property (p_exit) else $error("stop exit path");
  property p_stab; $fell(mode_out == 2'd3)
    |-> stab_cnt == STAB_CYCLES && mode_out == 2'd0; endproperty
  a_stab: assert property (p_stab) else $error("restart wait length");
  property p_wake; mode_out == 2'd1 && (timer16_irq_in || serial_irq_in)
    |-> ##[1:3] mode_out == 2'd0; endproperty
  a_wake: assert property (p_wake) else $error("wait not left");
  property p_went; $rose(mode_out == 2'd1) |-> !irq_mask_out; endproperty
  a_went: assert property (p_went) else $error("wait mask set");
  property p_prst; $past(sys_rst_in)
    |-> port_oe_out == 6'h00 && port_pullup_out == 6'h3F; endproperty
  a_prst: assert property (p_prst) else $error("port reset state");
endmodule
bind lpmc lpmc_checker #(.STOP_DISABLE(STOP_DISABLE),
  .STAB_CYCLES(STAB_CYCLES)) lpmc_checker_i (.clock_in(clock_in),
  .sys_rst_in(sys_rst_in), .reset_n_pin_in(reset_n_pin_in),
  .stop_exec_in(stop_exec_in), .wait_exec_in(wait_exec_in),
  .irq_mask_out(irq_mask_out), .core_irq_out(core_irq_out),
  .bus_clk_en_out(bus_clk_en_out), .mode_out(mode_out),
  .ext_irq_n_pin_in(ext_irq_n_pin_in), .timer16_irq_in(timer16_irq_in),
  .serial_irq_in(serial_irq_in), .port_oe_out(port_oe_out),
  .port_pullup_out(port_pullup_out));
`default_nettype wire

// ===== lpmc_peer.sv
`timescale 1ns/1ps
`default_nettype none
module lpmc_peer (
  // Clock
  input wire logic clock_in,
  // Pins towards the device
  output logic reset_n_pin_out,
  output logic ext_irq_n_pin_out,
  output logic timer16_irq_out,
  output logic serial_irq_out
);
  initial
  begin
    reset_n_pin_out = 1'b1;
    ext_irq_n_pin_out = 1'b1;
    timer16_irq_out = 1'b0;
    serial_irq_out = 1'b0;
  end
  // Reset stays low across the whole low-supply span
  task automatic retention(input int n);
    @(posedge clock_in);
    reset_n_pin_out <= 1'b0;
    repeat (n) @(posedge clock_in);
    reset_n_pin_out <= 1'b1;
  endtask
  // Source 0 is the external pin, 1 the timer, 2 the serial unit
  task automatic pulse(input int src, input int n);
    @(posedge clock_in);
    ext_irq_n_pin_out <= (src != 0);
    timer16_irq_out <= (src == 1);
    serial_irq_out <= (src == 2);
    repeat (n) @(posedge clock_in);
    ext_irq_n_pin_out <= 1'b1;
    timer16_irq_out <= 1'b0;
    serial_irq_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_params.svh"
module tb_top;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic stop_exec_in = 1'b0;
  logic wait_exec_in = 1'b0;
  logic [5:0] port_pin_in = 6'h00;
  lpmc_pkg::lpmc_req_s req_in = '0;
  lpmc_pkg::lpmc_periph_s t16_pins = '0, ser_pins = '0;
  logic rst_n, ext_n, t16_irq, ser_irq, halt, mask, cirq, osc, ben, pen;
  logic [1:0] mode_out, mode_ns;
  logic [7:0] rdata_out, q;
  logic [11:0] e;
  logic [5:0] dout, oe, pull, din;
  int n_errors = 0, checked = 0, seed = 54;
  always #2.5 clock_in = ~clock_in;
  lpmc_peer lpmc_peer_i (.clock_in(clock_in), .reset_n_pin_out(rst_n),
    .ext_irq_n_pin_out(ext_n), .timer16_irq_out(t16_irq),
    .serial_irq_out(ser_irq));
  lpmc #(.STAB_CYCLES(8), .PRESC_W(2)) lpmc_i (.clock_in(clock_in),
    .sys_rst_in(sys_rst_in), .reset_n_pin_in(rst_n), .req_in(req_in),
    .rdata_out(rdata_out), .stop_exec_in(stop_exec_in),
    .wait_exec_in(wait_exec_in), .cpu_halt_out(halt), .irq_mask_out(mask),
    .core_irq_out(cirq), .osc_on_out(osc), .bus_clk_en_out(ben),
    .periph_clk_en_out(pen), .mode_out(mode_out), .ext_irq_n_pin_in(ext_n),
    .timer16_irq_in(t16_irq), .serial_irq_in(ser_irq),
    .port_pin_in(port_pin_in), .timer16_pins_in(t16_pins),
    .serial_pins_in(ser_pins), .port_dout_out(dout), .port_oe_out(oe),
    .port_pullup_out(pull), .port_din_out(din));
  // Mask-option variant sees the same stimulus
  lpmc #(.STOP_DISABLE(1'b1), .STAB_CYCLES(8), .PRESC_W(2)) lpmc_nostop_i (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .reset_n_pin_in(rst_n),
    .req_in(req_in), .rdata_out(), .stop_exec_in(stop_exec_in),
    .wait_exec_in(wait_exec_in), .cpu_halt_out(), .irq_mask_out(),
    .core_irq_out(), .osc_on_out(), .bus_clk_en_out(),
    .periph_clk_en_out(), .mode_out(mode_ns), .ext_irq_n_pin_in(ext_n),
    .timer16_irq_in(t16_irq), .serial_irq_in(ser_irq),
    .port_pin_in(port_pin_in), .timer16_pins_in(t16_pins),
    .serial_pins_in(ser_pins), .port_dout_out(), .port_oe_out(),
    .port_pullup_out(), .port_din_out());
  ////////////////////////////////////////////////////////////////////////
  task wrap_up;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [11:0] s, input logic [11:0] x);
    checked++;
    if (s !== x)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_in);
    req_in <= {a, d, 2'b10};
    @(posedge clock_in);
    req_in.wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock_in);
    req_in <= {a, 8'h00, 2'b01};
    @(posedge clock_in);
    req_in.rd <= 1'b0;
    #1;
    d = rdata_out;
  endtask
  task op(input bit s);
    @(posedge clock_in);
    stop_exec_in <= s;
    wait_exec_in <= !s;
    @(posedge clock_in);
    stop_exec_in <= 1'b0;
    wait_exec_in <= 1'b0;
    @(posedge clock_in);
    #1;
  endtask
  // Bounded wait; running out ends the run as a failure
  task wmode(input logic [1:0] m, input int n);
    int k;
    k = 0;
    while (mode_out !== m && k < n)
    begin
      @(posedge clock_in);
      #1;
      k++;
    end
    if (mode_out !== m)
    begin
      n_errors++;
      wrap_up();
    end
  endtask
  function automatic logic [11:0] route(input logic [5:0] c, input bit s);
    lpmc_pkg::lpmc_periph_s p;
    p = s ? ser_pins : t16_pins;
    return {p.dout & p.oe & c, p.oe & c};
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    repeat (6) @(posedge clock_in);
    rd(`LPMC_OFS_CCR, q);
    chk("ccr", q, `LPMC_RST_CCR);
    rd(`LPMC_OFS_PCONN, q);
    chk("conn", q, 8'h00);
    chk("pull", pull, 6'h3F);
    wr(`LPMC_OFS_PDATA, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr(`LPMC_OFS_PSEL, i[0] ? 8'h3F : 8'h00);
      t16_pins <= 12'($random(seed));
      ser_pins <= 12'($random(seed));
      port_pin_in <= 6'($random(seed));
      q = 8'($random(seed));
      wr(`LPMC_OFS_PCONN, q);
      repeat (2) @(posedge clock_in);
      #1;
      e = route(q[5:0], i[0]);
      chk("route", {dout & oe, oe}, e);
      chk("pull", pull, 6'(~q[5:0]));
      rd(`LPMC_OFS_PDATA, q);
      chk("din_reg", q, {2'h0, port_pin_in});
      chk("din", din, port_pin_in);
    end
    wr(`LPMC_OFS_PDIR, 8'h2A);
    wr(`LPMC_OFS_CTCS, 8'h32);
    op(1'b1);
    chk("mode", {osc, mask, mode_out}, 4'h2);
    chk("nop", mode_ns, 2'd0);
    // One source at a time, so the peer never drives a pin twice per step
    lpmc_peer_i.pulse(1, 12);
    lpmc_peer_i.pulse(2, 12);
    #1;
    chk("mode", mode_out, 2'd2);
    lpmc_peer_i.pulse(0, 3);
    wmode(2'd0, 60);
    rd(`LPMC_OFS_CTCS, q);
    chk("ctcs", q & 8'h33, 8'h02);
    rd(`LPMC_OFS_PDIR, q);
    chk("dir", q, 8'h2A);
    for (int s = 1; s < 4; s++)
    begin
      if (s == 3)
        wr(`LPMC_OFS_CTCS, 8'hD0);
      op(1'b0);
      chk("wait", {halt, mask, mode_out}, 4'h9);
      q = 8'h00;
      repeat (4)
      begin
        @(posedge clock_in);
        #1;
        q += 8'({pen, ben});
      end
      if (s < 3)
        chk("clk_en", q, 8'h04);
      if (s < 3)
        lpmc_peer_i.pulse(s, 2 * s);
      wmode(2'd0, 400);
      chk("wake", mode_out, 2'd0);
      if (s == 3)
        chk("core_irq", cirq, 1'b1);
    end
    wr(`LPMC_OFS_PCONN, 8'h3F);
    fork
      lpmc_peer_i.retention(12);
      begin
        repeat (9) @(posedge clock_in);
        #1;
        chk("pin_rst", {mask, pull}, 7'h7F);
      end
    join
    repeat (8) @(posedge clock_in);
    rd(`LPMC_OFS_PCONN, q);
    chk("conn", q, 8'h00);
    wr(`LPMC_OFS_PDIR, 8'h15);
    rd(`LPMC_OFS_PDIR, q);
    chk("dir", q, 8'h15);
    wrap_up();
  end
endmodule
`default_nettype wire
